//--- adc_config_pkg.sv
// Purpose: shared constants for the converter configuration register map
// Assumes: 15-bit register address, 8-bit register data
// Notes:   all offsets and reset values live here; the power and class field slices are coded in config_store
`default_nettype none
package adc_config_pkg;

  // ------------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int FLAG_W = 7;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 15'h0001;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_SETUP    = 15'h0000;
  localparam logic [ADDR_W-1:0] ADDR_POWER    = 15'h0002;
  localparam logic [ADDR_W-1:0] ADDR_CLASS    = 15'h0003;
  localparam logic [ADDR_W-1:0] ADDR_ID_LO    = 15'h0004;
  localparam logic [ADDR_W-1:0] ADDR_ID_HI    = 15'h0005;
  localparam logic [ADDR_W-1:0] ADDR_REV      = 15'h0006;
  localparam logic [ADDR_W-1:0] ADDR_MAKER_LO = 15'h000C;
  localparam logic [ADDR_W-1:0] ADDR_MAKER_HI = 15'h000D;
  localparam logic [ADDR_W-1:0] ADDR_LINK     = 15'h006C;

  // ------------------------------------------------------------------
  // interface_setup fields
  // ------------------------------------------------------------------
  localparam int SETUP_REINIT_BIT = 7;
  localparam int SETUP_RSVD_BIT   = 6;
  localparam int SETUP_UP_BIT     = 5;
  localparam logic [1:0] SETUP_STORED_RESET = 2'h1;  // bit6=0, bit5=1
  localparam logic       SETUP_FIXED_ONE    = 1'h1;  // bit 4

  localparam logic [DATA_W-1:0] POWER_RESET    = 8'h00;
  localparam logic [3:0]        CLASS_HI_RESET = 4'h0;

  // ------------------------------------------------------------------
  // plain read/write registers: offsets and reset values
  // ------------------------------------------------------------------
  localparam int RW_COUNT = 10;
  localparam logic [ADDR_W-1:0] RW_OFFSET [RW_COUNT] = '{
    15'h0010, 15'h0012, 15'h0013, 15'h0014, 15'h003D,
    15'h0047, 15'h0060, 15'h0061, 15'h0062, 15'h0063};
  localparam logic [DATA_W-1:0] RW_RESET [RW_COUNT] = '{
    8'h01, 8'h81, 8'h20, 8'h00, 8'h00,
    8'h00, 8'h7D, 8'h00, 8'h01, 8'h00};

  typedef enum logic [1:0] {
    LP_NORMAL   = 2'h0,
    LP_RESERVED = 2'h1,
    LP_SLEEP    = 2'h2,
    LP_OFF      = 2'h3
  } low_power_t;

  // ------------------------------------------------------------------
  // serial command framing
  // ------------------------------------------------------------------
  localparam logic [3:0] HDR_LAST  = 4'hF;
  localparam logic [3:0] HDR_FIRST = 4'h1;
  localparam logic [2:0] DATA_LAST = 3'h7;
  localparam logic       CMD_READ  = 1'h1;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_HEADER = 2'h1,
    ST_DATA   = 2'h3
  } spi_state_t;

endpackage : adc_config_pkg
`default_nettype wire

//--- config_store.sv
// Purpose: register storage and read decode of the configuration map
// Assumes: one write strobe per completed data word
// Notes:   read data is combinational from the read address
`timescale 1ns/1ns
`default_nettype none
module config_store
  import adc_config_pkg::*;
#(
  parameter logic [3:0]  PART_CLASS_CODE = 4'hA,     // arbitrary value
  parameter logic [15:0] PART_ID         = 16'h5A3C, // arbitrary value
  parameter logic [7:0]  PART_REV        = 8'h07,    // arbitrary value
  parameter logic [15:0] MAKER_CODE      = 16'hC3E1  // arbitrary value
)(
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   ce_i,
  input  wire logic                   wr_en_i,
  input  wire logic [ADDR_W-1:0]      wr_addr_i,
  input  wire logic [DATA_W-1:0]      wr_data_i,
  input  wire logic [ADDR_W-1:0]      rd_addr_i,
  input  wire logic [FLAG_W-1:0]      link_flags_i,
  output logic      [DATA_W-1:0]      rd_data_o,
  output logic                        stream_up_o,
  output logic      [1:0]             low_power_o,
  output logic [RW_COUNT*DATA_W-1:0]  settings_o
);

  logic [1:0]        setup_r, setup_nxt;
  logic [DATA_W-1:0] power_r, power_nxt;
  logic [3:0]        class_hi_r, class_hi_nxt;
  logic              reinit;

  // soft reset wins over the write that carries it
  assign reinit = wr_en_i && (wr_addr_i == ADDR_SETUP)
                  && wr_data_i[SETUP_REINIT_BIT];                 // [R01]

  // ------------------------------------------------------------------
  // fixed-layout registers
  // ------------------------------------------------------------------
  always_comb
  begin
    setup_nxt    = setup_r;
    power_nxt    = power_r;
    class_hi_nxt = class_hi_r;
    if (reinit)
    begin
      setup_nxt    = SETUP_STORED_RESET;                          // [R01]
      power_nxt    = POWER_RESET;
      class_hi_nxt = CLASS_HI_RESET;
    end
    else if (wr_en_i)
    begin
      if (wr_addr_i == ADDR_SETUP)
        setup_nxt = wr_data_i[SETUP_RSVD_BIT:SETUP_UP_BIT];       // [R03]
      else if (wr_addr_i == ADDR_POWER)
        power_nxt = wr_data_i;                                    // [R07]
      else if (wr_addr_i == ADDR_CLASS)
        class_hi_nxt = wr_data_i[7:4];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      setup_r    <= SETUP_STORED_RESET;
      power_r    <= POWER_RESET;
      class_hi_r <= CLASS_HI_RESET;
    end
    else if (ce_i)
    begin
      setup_r    <= setup_nxt;
      power_r    <= power_nxt;
      class_hi_r <= class_hi_nxt;
    end
  end

  // ------------------------------------------------------------------
  // plain read/write registers
  // ------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < RW_COUNT; g++)
    begin : g_rw
      logic [DATA_W-1:0] val_r, val_nxt;
      always_comb
      begin
        val_nxt = val_r;
        if (reinit)
          val_nxt = RW_RESET[g];                                  // [R01]
        else if (wr_en_i && (wr_addr_i == RW_OFFSET[g]))
          val_nxt = wr_data_i;
      end
      always_ff @(posedge clk_i)
      begin
        if (reset_i)
          val_r <= RW_RESET[g];
        else if (ce_i)
          val_r <= val_nxt;
      end
      assign settings_o[g*DATA_W +: DATA_W] = val_r;
    end
  endgenerate

  // ------------------------------------------------------------------
  // read decode
  // ------------------------------------------------------------------
  function automatic logic [DATA_W-1:0] setup_word(input logic [1:0] s);
    logic [3:0] hi;
    hi = {1'b0, s, SETUP_FIXED_ONE};                              // [R02]
    setup_word = {hi, hi[0], hi[1], hi[2], hi[3]};                // [R04]
  endfunction : setup_word

  always_comb
  begin
    rd_data_o = '0;                                               // [R13]
    if (rd_addr_i == ADDR_SETUP)
      rd_data_o = setup_word(setup_r);
    else if (rd_addr_i == ADDR_POWER)
      rd_data_o = power_r;
    else if (rd_addr_i == ADDR_CLASS)
      rd_data_o = {class_hi_r, PART_CLASS_CODE};                  // [R09]
    else if (rd_addr_i == ADDR_ID_LO)
      rd_data_o = PART_ID[7:0];
    else if (rd_addr_i == ADDR_ID_HI)
      rd_data_o = PART_ID[15:8];
    else if (rd_addr_i == ADDR_REV)
      rd_data_o = PART_REV;
    else if (rd_addr_i == ADDR_MAKER_LO)
      rd_data_o = MAKER_CODE[7:0];
    else if (rd_addr_i == ADDR_MAKER_HI)
      rd_data_o = MAKER_CODE[15:8];
    else if (rd_addr_i == ADDR_LINK)
      rd_data_o = {1'b0, link_flags_i};                           // [R14]
    else
      for (int i = 0; i < RW_COUNT; i++)
        if (rd_addr_i == RW_OFFSET[i])
          rd_data_o = settings_o[i*DATA_W +: DATA_W];
  end

  assign stream_up_o = setup_r[0];
  assign low_power_o = power_r[1:0];

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  chk_reinit_restores: assert property (@(posedge clk_i) disable iff (reset_i) // [R01]
    ce_i && reinit |=> stream_up_o && (low_power_o == LP_NORMAL)
      && (settings_o[DATA_W-1:0] == RW_RESET[0]))
    else $error("soft reset left a register off its default");
  chk_reinit_reads_zero: assert property (@(posedge clk_i) disable iff (reset_i) // [R02]
    (rd_addr_i == ADDR_SETUP) |-> !rd_data_o[SETUP_REINIT_BIT])
    else $error("soft reset bit reads back as one");
  chk_mirror_nibble: assert property (@(posedge clk_i) disable iff (reset_i) // [R04]
    (rd_addr_i == ADDR_SETUP) |-> rd_data_o[3:0] ==
      {rd_data_o[4], rd_data_o[5], rd_data_o[6], rd_data_o[7]})
    else $error("low nibble does not mirror high nibble");
  chk_power_select: assert property (@(posedge clk_i) disable iff (reset_i) // [R07]
    ce_i && wr_en_i && (wr_addr_i == ADDR_POWER) |=>
      low_power_o == $past(wr_data_i[1:0]))
    else $error("power state not taken from write");
  chk_class_code: assert property (@(posedge clk_i) disable iff (reset_i) // [R09]
    (rd_addr_i == ADDR_CLASS) |-> rd_data_o[3:0] == PART_CLASS_CODE)
    else $error("part class code changed");
  chk_reserved_zero: assert property (@(posedge clk_i) disable iff (reset_i) // [R13]
    (rd_addr_i == 15'h0001 || rd_addr_i == 15'h0020) |-> rd_data_o == '0)
    else $error("reserved address reads nonzero");
  chk_link_top_zero: assert property (@(posedge clk_i) disable iff (reset_i) // [R14]
    (rd_addr_i == ADDR_LINK) |-> !rd_data_o[7]
      && rd_data_o[FLAG_W-1:0] == link_flags_i)
    else $error("link status not live");
  cov_soft_reset: cover property (@(posedge clk_i) ce_i && reinit);

endmodule : config_store
`default_nettype wire

//--- adc_config_register_map.sv
// Purpose: serial-port slave and register map of a single-channel converter
// Assumes: serial pins already synchronous to clk_i, sclk well below clk_i/4
// Notes:   sdo is driven from the falling sclk edge after each data start
//
// Summary of operation
// R01: writing one to bit 7 of interface_setup returns every register to default.
// R02: the soft-reset bit is never stored, so it always reads back as zero.
// R03: bit 5 of interface_setup picks increment (1, default) or decrement.
// R04: the low nibble of interface_setup reads as the bit-reverse of the high.
// R05: the host writes one into bit 4, which the device holds at one anyway.
// R06: the host writes zero into reserved bit 6 of interface_setup.
// R07: the two-bit power field selects normal, reserved, sleep or power-down.
// R08: the host writes the six upper power-state bits as zero.
// R09: the low four bits of part_class are a fixed read-only class code.
// R10: the host writes the upper four bits of part_class as zero.
// R11: a command is one read/write bit, a 15-bit address and an 8-bit word.
// R12: each further streamed word goes to the adjacent register.
// R13: reserved addresses read zero and ignore writes.
// R14: link_state_flags is read-only live status with its top bit zero.
`timescale 1ns/1ns
`default_nettype none
module adc_config_register_map
  import adc_config_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   ce_i,
  input  wire logic                   spi_sclk_i,
  input  wire logic                   spi_cs_n_i,
  input  wire logic                   spi_sdi_i,
  input  wire logic [FLAG_W-1:0]      link_flags_i,
  output logic                        spi_sdo_o,
  output logic                        spi_sdo_oe_o,
  output logic      [1:0]             low_power_select_o,
  output logic                        stream_direction_up_o,
  output logic [RW_COUNT*DATA_W-1:0]  mode_settings_o
);

  spi_state_t        state_r, state_nxt;
  logic              sclk_prev_r, sclk_prev_nxt;
  logic [3:0]        hcnt_r, hcnt_nxt;
  logic [2:0]        dcnt_r, dcnt_nxt;
  logic              is_read_r, is_read_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] shift_in_r, shift_in_nxt;
  logic [6:0]        shift_out_r, shift_out_nxt;
  logic              sdo_r, sdo_nxt;
  logic              sdo_oe_r, sdo_oe_nxt;
  logic              wr_en_r, wr_en_nxt;
  logic [ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
  logic [DATA_W-1:0] wr_data_r, wr_data_nxt;
  logic [DATA_W-1:0] rd_data;
  logic              rise, fall, word_done;

  assign rise      = spi_sclk_i && !sclk_prev_r;
  assign fall      = !spi_sclk_i && sclk_prev_r;
  assign word_done = !spi_cs_n_i && (state_r == ST_DATA) && rise
                     && (dcnt_r == DATA_LAST);

  // ------------------------------------------------------------------
  // serial command engine
  // ------------------------------------------------------------------
  always_comb
  begin
    state_nxt     = state_r;
    sclk_prev_nxt = spi_sclk_i;
    hcnt_nxt      = hcnt_r;
    dcnt_nxt      = dcnt_r;
    is_read_nxt   = is_read_r;
    addr_nxt      = addr_r;
    shift_in_nxt  = shift_in_r;
    shift_out_nxt = shift_out_r;
    sdo_nxt       = sdo_r;
    sdo_oe_nxt    = sdo_oe_r;
    wr_en_nxt     = 1'b0;
    wr_addr_nxt   = wr_addr_r;
    wr_data_nxt   = wr_data_r;
    if (spi_cs_n_i)
    begin
      // deselect aborts any partial word, nothing is written
      state_nxt  = ST_IDLE;
      hcnt_nxt   = '0;
      dcnt_nxt   = '0;
      sdo_oe_nxt = 1'b0;                                          // [R11]
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (rise)
          begin
            is_read_nxt = spi_sdi_i;                              // [R11]
            hcnt_nxt    = HDR_FIRST;
            state_nxt   = ST_HEADER;
          end
        end
        ST_HEADER:
        begin
          if (rise)
          begin
            addr_nxt = {addr_r[ADDR_W-2:0], spi_sdi_i};           // [R11]
            hcnt_nxt = 4'(hcnt_r + 4'h1);
            if (hcnt_r == HDR_LAST)
            begin
              state_nxt  = ST_DATA;
              dcnt_nxt   = '0;
              sdo_oe_nxt = (is_read_r == CMD_READ);
            end
          end
        end
        ST_DATA:
        begin
          if (fall && is_read_r)
          begin
            // reload at each word start so streamed reads see the new address
            if (dcnt_r == '0)
              {sdo_nxt, shift_out_nxt} = rd_data;
            else
              {sdo_nxt, shift_out_nxt} = {shift_out_r, 1'b0};
          end
          if (rise)
          begin
            shift_in_nxt = {shift_in_r[6:0], spi_sdi_i};
            dcnt_nxt     = 3'(dcnt_r + 3'h1);
            if (dcnt_r == DATA_LAST)
            begin
              wr_en_nxt   = !is_read_r;                           // [R11]
              wr_addr_nxt = addr_r;
              wr_data_nxt = {shift_in_r[6:0], spi_sdi_i};
              addr_nxt    = stream_direction_up_o                 // [R03]
                            ? addr_r + ADDR_ONE                   // [R12]
                            : addr_r - ADDR_ONE;
            end
          end
        end
        default:
          state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_r     <= ST_IDLE;
      sclk_prev_r <= 1'b0;
      hcnt_r      <= '0;
      dcnt_r      <= '0;
      is_read_r   <= 1'b0;
      addr_r      <= '0;
      shift_in_r  <= '0;
      shift_out_r <= '0;
      sdo_r       <= 1'b0;
      sdo_oe_r    <= 1'b0;
      wr_en_r     <= 1'b0;
      wr_addr_r   <= '0;
      wr_data_r   <= '0;
    end
    else if (ce_i)
    begin
      state_r     <= state_nxt;
      sclk_prev_r <= sclk_prev_nxt;
      hcnt_r      <= hcnt_nxt;
      dcnt_r      <= dcnt_nxt;
      is_read_r   <= is_read_nxt;
      addr_r      <= addr_nxt;
      shift_in_r  <= shift_in_nxt;
      shift_out_r <= shift_out_nxt;
      sdo_r       <= sdo_nxt;
      sdo_oe_r    <= sdo_oe_nxt;
      wr_en_r     <= wr_en_nxt;
      wr_addr_r   <= wr_addr_nxt;
      wr_data_r   <= wr_data_nxt;
    end
  end

  assign spi_sdo_o    = sdo_r;
  assign spi_sdo_oe_o = sdo_oe_r;

  // ------------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------------
  config_store u_store (
    .clk_i        (clk_i),
    .reset_i      (reset_i),
    .ce_i         (ce_i),
    .wr_en_i      (wr_en_r),
    .wr_addr_i    (wr_addr_r),
    .wr_data_i    (wr_data_r),
    .rd_addr_i    (addr_r),
    .link_flags_i (link_flags_i),
    .rd_data_o    (rd_data),
    .stream_up_o  (stream_direction_up_o),
    .low_power_o  (low_power_select_o),
    .settings_o   (mode_settings_o)
  );

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  chk_stream_step: assert property (@(posedge clk_i) disable iff (reset_i) // [R12]
    ce_i && word_done |=> addr_r == ($past(stream_direction_up_o)
      ? $past(addr_r) + ADDR_ONE : $past(addr_r) - ADDR_ONE))
    else $error("streamed address did not step by one");
  chk_write_from_word: assert property (@(posedge clk_i) disable iff (reset_i) // [R11]
    ce_i && word_done && !is_read_r |=> wr_en_r
      && wr_addr_r == $past(addr_r))
    else $error("completed write word not strobed");
  chk_sdo_release: assert property (@(posedge clk_i) disable iff (reset_i) // [R11]
    ce_i && spi_cs_n_i |=> !spi_sdo_oe_o)
    else $error("sdo still driven after deselect");
  chk_read_only_drive: assert property (@(posedge clk_i) disable iff (reset_i) // [R11]
    spi_sdo_oe_o |-> is_read_r && state_r == ST_DATA)
    else $error("sdo driven outside a read");
  cov_write_word: cover property (@(posedge clk_i) wr_en_r);
  cov_read_start: cover property (@(posedge clk_i) $rose(spi_sdo_oe_o));
  cov_stream_two: cover property (@(posedge clk_i)
    word_done ##[1:300] word_done);

endmodule : adc_config_register_map
`default_nettype wire

//--- spi_host_model.sv
// Purpose: serial-port host model that drives the register map's pins
// Assumes: clk_i is the design clock; sclk stays low for two clk periods and high for three
// Notes:   frame() sends up to eight streamed words, MSB first
`timescale 1ns/1ns
`default_nettype none
module spi_host_model
(
  input  wire logic clk_i,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o
);
  // ------------------------------------------------------------------
  // serial frame
  // ------------------------------------------------------------------
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
  end

  // cut > 0 stops after that many rises, which aborts the word in flight
  task automatic frame(input logic rd, input logic [14:0] a, input int n,
                       input int cut, input logic [63:0] wd,
                       output logic [63:0] rv);
    logic [15:0] hdr;
    int          total;
    logic        b;
    hdr   = {rd, a};
    total = (cut > 0) ? cut : 16 + 8 * n;
    rv    = 64'h0;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = 0; i < total; i++)
    begin
      b = (i < 16) ? hdr[15 - i] : wd[63 - (i - 16)];
      @(posedge clk_i);
      sclk_o <= 1'b0;
      sdi_o  <= b;
      repeat (2) @(posedge clk_i);
      sclk_o <= 1'b1;
      // an undriven sdo must not pass for the right bit
      if (i >= 16)
        rv[63 - (i - 16)] = sdo_oe_i ? sdo_i : ~sdo_i;
      repeat (2) @(posedge clk_i);
    end
    @(posedge clk_i);
    sclk_o <= 1'b0;
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    sdi_o  <= ~sdi_o;  // released line shows no stale level
    repeat (4) @(posedge clk_i);
  endtask : frame
endmodule : spi_host_model
`default_nettype wire

//--- adc_config_register_map_bench.sv
// Purpose: self-checking bench for the converter register map
// Assumes: spi_host_model drives the serial pins; class code default 4'hA
// Notes:   expected contents live in exp_set, never read back from the dut
`timescale 1ns/1ns
`default_nettype none
module adc_config_register_map_bench
  import adc_config_pkg::*;
;
  localparam logic [3:0] CLASS_CODE = 4'hA;  // arbitrary, design default
  logic                       clk_i;
  logic                       reset_i;
  logic                       ce_i;
  logic                       sclk;
  logic                       cs_n;
  logic                       sdi;
  logic                       sdo;
  logic                       sdo_oe;
  logic [FLAG_W-1:0]          flags;
  logic [1:0]                 low_power;
  logic                       stream_up;
  logic [RW_COUNT*DATA_W-1:0] settings;
  logic [DATA_W-1:0]          exp_set [RW_COUNT];
  logic                       exp_up;
  logic [31:0]                rng;
  logic [63:0]                rv;
  logic [7:0]                 d0;
  logic [7:0]                 d1;
  logic [7:0]                 d2;
  int                         bad_count;
  int                         checks;

  adc_config_register_map u_dut (
    .clk_i                 (clk_i),
    .reset_i               (reset_i),
    .ce_i                  (ce_i),
    .spi_sclk_i            (sclk),
    .spi_cs_n_i            (cs_n),
    .spi_sdi_i             (sdi),
    .link_flags_i          (flags),
    .spi_sdo_o             (sdo),
    .spi_sdo_oe_o          (sdo_oe),
    .low_power_select_o    (low_power),
    .stream_direction_up_o (stream_up),
    .mode_settings_o       (settings)
  );

  spi_host_model u_host (
    .clk_i    (clk_i),
    .sdo_i    (sdo),
    .sdo_oe_i (sdo_oe),
    .sclk_o   (sclk),
    .cs_n_o   (cs_n),
    .sdi_o    (sdi)
  );

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [7:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction : rnd

  function automatic logic [79:0] exp_vec();
    logic [79:0] v;
    for (int i = 0; i < RW_COUNT; i++)
      v[i*8 +: 8] = exp_set[i];
    return v;
  endfunction : exp_vec

  task automatic cmp(input logic [79:0] got, input logic [79:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // data right-aligned, first word highest
  task automatic put(input logic [14:0] a, input int n,
                     input logic [63:0] wd, input int cut);
    u_host.frame(1'b0, a, n, cut, wd << (64 - 8 * n), rv);
    if (cut == 0)
      for (int j = 0; j < n; j++)
      begin
        for (int k = 0; k < RW_COUNT; k++)
          if (RW_OFFSET[k] == a)
            exp_set[k] = wd[8 * (n - 1 - j) +: 8];
        a = exp_up ? a + 15'h1 : a - 15'h1;
      end
  endtask : put

  task automatic get(input logic [14:0] a, input int n,
                     input logic [63:0] exp);
    u_host.frame(1'b1, a, n, 0, 64'h0, rv);
    cmp({16'h0, rv >> (64 - 8 * n)}, {16'h0, exp});
    cmp({79'h0, sdo_oe}, 80'h0);
  endtask : get

  task automatic defaults();
    exp_up = 1'b1;
    for (int i = 0; i < RW_COUNT; i++)
      exp_set[i] = RW_RESET[i];
  endtask : defaults

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // ------------------------------------------------------------------
  // clock and watchdog
  // ------------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // about 45 frames of at most 207 cycles each, so generous margin
  initial
  begin
    repeat (30000) @(posedge clk_i);
    bad_count++;
    summarize();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    reset_i   = 1'b1;
    ce_i      = 1'b1;
    flags     = '0;
    rng       = 32'h7879973B;
    bad_count = 0;
    checks    = 0;
    defaults();
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    cmp({77'h0, low_power, stream_up}, 80'h1);
    cmp(settings, exp_vec());
    get(ADDR_SETUP, 1, 64'h3C);
    get(15'h0001, 1, 64'h0);
    get(15'h006D, 1, 64'h0);
    get(ADDR_CLASS, 1, {60'h0, CLASS_CODE});
    for (int p = 0; p < 4; p++)
    begin
      put(ADDR_POWER, 1, {62'h0, p[1:0]}, 0);
      cmp({78'h0, low_power}, {78'h0, p[1:0]});
      get(ADDR_POWER, 1, {62'h0, p[1:0]});
    end
    repeat (4)
    begin
      d0 = rnd();
      flags <= d0[6:0];
      @(posedge clk_i);
      get(ADDR_LINK, 1, {57'h0, d0[6:0]});
    end
    // ascending stream, then read it back as a stream
    d0 = rnd();
    d1 = rnd();
    d2 = rnd();
    put(15'h0012, 3, {40'h0, d0, d1, d2}, 0);
    cmp(settings, exp_vec());
    get(15'h0012, 3, {40'h0, d0, d1, d2});
    // descending direction
    put(ADDR_SETUP, 1, 64'h10, 0);
    exp_up = 1'b0;
    cmp({79'h0, stream_up}, 80'h0);
    get(ADDR_SETUP, 1, 64'h18);
    put(15'h0063, 3, {40'h0, d2, d1, d0}, 0);
    cmp(settings, exp_vec());
    get(15'h0014, 2, {48'h0, exp_set[3], exp_set[2]});
    // read-only and reserved places ignore writes
    put(ADDR_CLASS, 1, 64'h05, 0);
    get(ADDR_CLASS, 1, {60'h0, CLASS_CODE});
    put(ADDR_LINK, 1, 64'hFF, 0);
    get(ADDR_LINK, 1, {57'h0, flags});
    put(15'h0001, 1, 64'hFF, 0);
    get(15'h0001, 1, 64'h0);
    // deselect after 20 rises drops the partial word
    put(15'h0010, 1, 64'hAA, 20);
    cmp(settings, exp_vec());
    repeat (6)
    begin
      d0 = rnd();
      d1 = rnd();
      put(RW_OFFSET[d0 % RW_COUNT], 1, {56'h0, d1}, 0);
      cmp(settings, exp_vec());
    end
    // soft reset from a non-default state
    put(ADDR_POWER, 1, 64'h03, 0);
    put(ADDR_SETUP, 1, 64'h90, 0);
    defaults();
    cmp({77'h0, low_power, stream_up}, 80'h1);
    cmp(settings, exp_vec());
    get(ADDR_SETUP, 1, 64'h3C);
    // clock enable low: a whole frame must go unseen
    ce_i <= 1'b0;
    put(15'h0010, 1, 64'h5A, 24);
    ce_i <= 1'b1;
    cmp(settings, exp_vec());
    // mid-run hardware reset from a non-default state
    put(ADDR_POWER, 1, 64'h02, 0);
    put(ADDR_SETUP, 1, 64'h10, 0);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    defaults();
    @(posedge clk_i);
    cmp({77'h0, low_power, stream_up}, 80'h1);
    cmp(settings, exp_vec());
    get(ADDR_POWER, 1, 64'h0);
    summarize();
  end
endmodule : adc_config_register_map_bench
`default_nettype wire
